// File: src/tshm_pkg.sv
// constants and types of the tdm slot handler with message channel
//
// Notes on behaviour
// - two octet and two two-bit channels, any slot
// - codec frames of 1 to 32 octets
// - every channel placed in any of 32 slots
// - terminal framing: 12 slots, command slots 3, 7
// - message slot 2+4n, 3 or 8 choices
// - second signal channel in bits 7:6, slot 7
// - linecard frame of up to eight 4-octet channels
// - slot field places unit; line bit picks lines
// - four cpu slot access channels, enable and swap
// - message channel select, line bit, enable bit
// - reset: channel 0, enabled, on downstream line
// - byte repeated each frame while the handshake is active
// - handshake control, ack/abort flags, active status
// - frame starts on frame sync rising edge only
// - double rate: shift first rise, sample second fall
// - new byte marked by one inactive handshake frame
// - two inactive handshake frames end a message
package tshm_pkg;
  localparam int             NUM_UNITS      = 8;
  localparam logic     [7:0] ADDR_BUS_CTRL  = 8'h00;
  localparam logic     [7:0] ADDR_MSG_CTRL  = 8'h04;
  localparam logic     [7:0] ADDR_MSG_TXD   = 8'h08;
  localparam logic     [7:0] ADDR_MSG_STATE = 8'h0C;
  localparam logic     [7:0] ADDR_IRQ_STS   = 8'h10;
  localparam logic     [7:0] ADDR_IRQ_CLR   = 8'h14;
  localparam logic     [7:0] ADDR_IRQ_EN    = 8'h18;
  localparam logic     [7:0] ADDR_FRAME     = 8'h1C;
  // unit blocks: index in addr[4:2], block in addr[7:5]
  localparam logic     [2:0] BLK_UNIT_CFG   = 3'h2;
  localparam logic     [2:0] BLK_UNIT_TXD   = 3'h3;
  localparam logic     [2:0] BLK_UNIT_RXD   = 3'h4;
  // unit order: bearer one, two, signal one, two, cpu access 0..3
  localparam int             UNIT_SIG_ONE   = 2;
  localparam int             UNIT_SIG_TWO   = 3;
  localparam int             CFG_SLOT_LSB   = 0;
  localparam int             CFG_LINE_BIT   = 5;
  localparam int             CFG_EN_BIT     = 6;
  localparam int             CFG_SWAP_BIT   = 7;
  localparam logic     [7:0] CFG_RST        = 8'h00;
  localparam int             BUS_MODE_LSB   = 0;
  localparam int             BUS_DBL_BIT    = 2;
  localparam int             BUS_SIG2CI_BIT = 3;
  localparam logic     [1:0] MODE_TERMINAL  = 2'h0;
  localparam logic     [1:0] MODE_LINECARD  = 2'h1;
  localparam logic     [1:0] MODE_CODEC     = 2'h2;
  localparam int             MSG_SEL_LSB    = 0;
  localparam int             MSG_LINE_BIT   = 3;
  localparam int             MSG_ON_BIT     = 4;
  localparam int             MSG_MXC_BIT    = 5;
  localparam int             MSG_MIE_BIT    = 6;
  localparam logic     [2:0] MSG_SEL_RST    = 3'h0;
  localparam logic     [2:0] MSG_SEL_TE_MAX = 3'h2;
  localparam logic     [4:0] MSG_SLOT_BASE  = 5'h02;
  localparam logic     [4:0] TE_SLOTS       = 5'h0C;
  localparam logic     [4:0] CI_FIRST_SLOT  = 5'h03;
  localparam logic     [4:0] CI_SECOND_SLOT = 5'h07;
  // bit positions in transmit order, msb first
  localparam logic     [2:0] POS_RX_ACK     = 3'h6;
  localparam logic     [2:0] POS_TX_HS      = 3'h7;
  localparam logic     [2:0] POS_SIG_LO     = 3'h6;
  localparam logic     [2:0] POS_SIG2_HI    = 3'h1;
  localparam int             IRQ_MDA        = 0;
  localparam int             IRQ_MAB        = 1;
  localparam int             IRQ_FRAME      = 2;
  localparam logic     [1:0] RESP_OKAY      = 2'h0;
  localparam logic     [1:0] RESP_SLVERR    = 2'h2;
  localparam logic     [1:0] END_FRAMES     = 2'h2;

  typedef enum logic [2:0] {
    TSHM_IDLE = 3'b000,
    TSHM_SEND = 3'b001,
    TSHM_WAIT = 3'b010,
    TSHM_GAP  = 3'b011,
    TSHM_END  = 3'b100
  } tshm_mst_t;
endpackage

// File: src/tshm_top.sv
// tdm slot handler: slot mapping, cpu slot access, message transmit handshake
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tshm_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        frame_sync,
  input  wire logic        bit_clk,
  input  wire logic        up_in,
  output logic             up_out,
  output logic             up_oe_n,
  input  wire logic        down_in,
  output logic             down_out,
  output logic             down_oe_n,
  output logic             irq
);
  import tshm_pkg::*;

  typedef struct packed {
    logic [2:0]            fs_s;
    logic [2:0]            bc_s;
    logic [1:0]            up_s;
    logic [1:0]            dn_s;
    logic [1:0]            mode;
    logic                  dbl;
    logic                  sig2_ci;
    logic [2:0]            msg_sel;
    logic                  msg_line;
    logic                  msg_on;
    logic                  tx_handshake_ctrl;
    logic                  msg_event_enable;
    logic [7:0]            msg_txd;
    logic                  pend;
    tshm_mst_t             mst;
    logic                  mx;
    logic                  mr_cur;
    logic                  mr_last;
    logic                  mr_seen;
    logic [1:0]            end_cnt;
    logic [2:0]            irq_sts;
    logic [2:0]            irq_en;
    logic [8:0]            bitcnt;
    logic                  phase;
    logic [5:0]            octets;
    logic [NUM_UNITS-1:0][7:0] cfg;
    logic [NUM_UNITS-1:0][7:0] txd;
    logic [NUM_UNITS-1:0][7:0] rxd;
    logic                  up_out;
    logic                  up_oe_n;
    logic                  dn_out;
    logic                  dn_oe_n;
    logic                  irq;
    logic                  awready;
    logic                  wready;
    logic                  aw_got;
    logic                  w_got;
    logic [7:0]            awaddr;
    logic [31:0]           wdata;
    logic                  wstrb0;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } tshm_state_t;

  tshm_state_t q;
  tshm_state_t d;

  logic            fs_rise;
  logic            bc_rise;
  logic            bc_fall;
  logic            shift_now;
  logic            sample_now;
  logic [8:0]      bidx;
  logic [4:0]      slot;
  logic [2:0]      bpos;
  logic            msg_ok;
  logic [4:0]      msg_slot;
  logic            ack;
  logic            abort;
  logic [2:0]      irq_set;
  logic [2:0]      irq_clr;
  logic            wr_ok;
  logic            rd_ok;
  logic [31:0]     rd_val;
  logic [NUM_UNITS-1:0] hit;
  logic [NUM_UNITS-1:0] eff_line;

  assign fs_rise = q.fs_s[1] & ~q.fs_s[2];
  assign bc_rise = q.bc_s[1] & ~q.bc_s[2];
  assign bc_fall = ~q.bc_s[1] & q.bc_s[2];
  assign shift_now  = bc_rise & (~q.dbl | ~q.phase | fs_rise);
  assign sample_now = bc_fall & (~q.dbl | q.phase);
  // only the rising edge restarts the frame
  assign bidx = fs_rise ? 9'h000 : q.bitcnt;
  assign slot = bidx[7:3];
  assign bpos = bidx[2:0];

  // message slot is 2 plus four per channel
  assign msg_slot = MSG_SLOT_BASE + {q.msg_sel, 2'b00};
  // terminal framing offers only three channels
  assign msg_ok = q.msg_on & ((q.mode != MODE_TERMINAL) | (q.msg_sel <= MSG_SEL_TE_MAX));
  assign ack   = q.mr_last & ~q.mr_cur;
  assign abort = q.mr_seen & q.mr_last & q.mr_cur;

  // per unit slot hit at the current bit
  always_comb
  begin
    for (int u = 0; u < NUM_UNITS; u++)
    begin
      logic [4:0] us;
      logic       bits_ok;
      us      = q.cfg[u][CFG_SLOT_LSB +: 5];
      bits_ok = 1'b1;
      eff_line[u] = q.cfg[u][CFG_LINE_BIT] ^ q.cfg[u][CFG_SWAP_BIT];
      // narrow channels use only bits 1:0
      if (u == UNIT_SIG_ONE || u == UNIT_SIG_TWO)
      begin
        bits_ok = (bpos >= POS_SIG_LO);
      end
      // second signal channel in bits 7:6 of slot 7
      if (u == UNIT_SIG_TWO && q.sig2_ci)
      begin
        us      = CI_SECOND_SLOT;
        bits_ok = (bpos <= POS_SIG2_HI);
      end
      // terminal framing keeps units within 12 slots
      // slot field picks the unit slot
      hit[u] = q.cfg[u][CFG_EN_BIT] & bits_ok & (slot == us) &
               ((q.mode != MODE_TERMINAL) | (us < TE_SLOTS));
    end
  end

  always_comb
  begin
    logic        pend_clr;
    logic        wr_hit;
    d          = q;
    pend_clr   = 1'b0;
    irq_set    = 3'h0;
    irq_clr    = 3'h0;
    wr_hit     = 1'b0;
    d.fs_s     = {q.fs_s[1:0], frame_sync};
    d.bc_s     = {q.bc_s[1:0], bit_clk};
    d.up_s     = {q.up_s[0], up_in};
    d.dn_s     = {q.dn_s[0], down_in};

    // slot counter restarts at frame start
    if (fs_rise)
    begin
      d.bitcnt = 9'h000;
      d.phase  = 1'b0;
      d.octets = q.bitcnt[8:3];
    end
    if (bc_fall && q.dbl)
    begin
      d.phase = ~q.phase;
    end
    // frame length follows the bit clock count
    if (sample_now && q.bitcnt != 9'h1FF)
    begin
      d.bitcnt = q.bitcnt + 9'h001;
    end

    // drive owned bits, release the rest
    if (shift_now)
    begin
      d.up_oe_n = 1'b1;
      d.dn_oe_n = 1'b1;
      d.up_out  = 1'b1;
      d.dn_out  = 1'b1;
      for (int u = 0; u < NUM_UNITS; u++)
      begin
        if (hit[u] && eff_line[u])
        begin
          d.up_out  = q.txd[u][3'h7 - bpos];
          d.up_oe_n = 1'b0;
        end
        if (hit[u] && !eff_line[u])
        begin
          d.dn_out  = q.txd[u][3'h7 - bpos];
          d.dn_oe_n = 1'b0;
        end
      end
      // message byte repeated every frame while active
      if (msg_ok && q.mst != TSHM_IDLE &&
          (slot == msg_slot || (slot == msg_slot + 5'h01 && bpos == POS_TX_HS)))
      begin
        if (q.msg_line)
        begin
          d.up_out  = (slot == msg_slot) ? q.msg_txd[3'h7 - bpos] : q.mx;
          d.up_oe_n = 1'b0;
        end
        else
        begin
          d.dn_out  = (slot == msg_slot) ? q.msg_txd[3'h7 - bpos] : q.mx;
          d.dn_oe_n = 1'b0;
        end
      end
    end

    // input taken from the opposite line
    if (sample_now)
    begin
      for (int u = 0; u < NUM_UNITS; u++)
      begin
        if (hit[u])
        begin
          d.rxd[u][3'h7 - bpos] = eff_line[u] ? q.dn_s[1] : q.up_s[1];
        end
      end
      if (msg_ok && slot == msg_slot + 5'h01 && bpos == POS_RX_ACK)
      begin
        d.mr_cur = q.msg_line ? q.dn_s[1] : q.up_s[1];
      end
    end

    // message handshake steps once per frame
    if (fs_rise)
    begin
      irq_set[IRQ_FRAME] = 1'b1;
      d.mr_last = q.mr_cur;
      case (q.mst)
        TSHM_IDLE:
        begin
          d.mx = 1'b1;
          if (q.tx_handshake_ctrl && msg_ok)
          begin
            d.mst     = TSHM_SEND;
            d.mx      = 1'b0;
            d.mr_seen = 1'b0;
            pend_clr  = 1'b1;
          end
        end
        TSHM_SEND, TSHM_WAIT:
        begin
          d.mr_seen = q.mr_seen | ~q.mr_cur;
          if (!q.tx_handshake_ctrl)
          begin
            d.mst     = TSHM_END;
            d.mx      = 1'b1;
            d.end_cnt = 2'h1;
          end
          else if (abort)
          begin
            // abort flag gated by event enable
            irq_set[IRQ_MAB] = q.msg_event_enable;
            d.mst     = TSHM_END;
            d.mx      = 1'b1;
            d.end_cnt = 2'h1;
          end
          else if (q.mst == TSHM_SEND && ack)
          begin
            // acknowledge flag gated by event enable
            irq_set[IRQ_MDA] = q.msg_event_enable;
            d.mst = TSHM_WAIT;
          end
          else if (q.mst == TSHM_WAIT && q.pend)
          begin
            // one inactive frame marks a new byte
            d.mst    = TSHM_GAP;
            d.mx     = 1'b1;
            pend_clr = 1'b1;
          end
        end
        TSHM_GAP:
        begin
          d.mst = TSHM_SEND;
          d.mx  = 1'b0;
        end
        TSHM_END:
        begin
          // two inactive frames end the message
          d.mx = 1'b1;
          if (q.end_cnt < END_FRAMES)
          begin
            d.end_cnt = q.end_cnt + 2'h1;
          end
          else if (q.mr_cur)
          begin
            d.mst = TSHM_IDLE;
          end
        end
        default:
        begin
          d.mst = TSHM_IDLE;
          d.mx  = 1'b1;
        end
      endcase
    end
    if (pend_clr)
    begin
      d.pend = 1'b0;
    end

    // bus slave: address and data taken in either order
    if (s_axi_awvalid && q.awready)
    begin
      d.awready = 1'b0;
      d.aw_got  = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.wready = 1'b0;
      d.w_got  = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (q.aw_got && q.w_got && !q.bvalid)
    begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      wr_hit   = 1'b1;
      d.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (wr_ok && q.wstrb0)
      begin
        case (q.awaddr)
          ADDR_BUS_CTRL:
          begin
            d.mode    = q.wdata[BUS_MODE_LSB +: 2];
            d.dbl     = q.wdata[BUS_DBL_BIT];
            d.sig2_ci = q.wdata[BUS_SIG2CI_BIT];
          end
          ADDR_MSG_CTRL:
          begin
            d.msg_sel  = q.wdata[MSG_SEL_LSB +: 3];
            d.msg_line = q.wdata[MSG_LINE_BIT];
            d.msg_on   = q.wdata[MSG_ON_BIT];
            d.tx_handshake_ctrl      = q.wdata[MSG_MXC_BIT];
            d.msg_event_enable      = q.wdata[MSG_MIE_BIT];
          end
          ADDR_MSG_TXD:
          begin
            // a write after the frame step still counts as pending
            d.msg_txd = q.wdata[7:0];
            d.pend    = 1'b1;
          end
          ADDR_IRQ_CLR: irq_clr = q.wdata[2:0];
          ADDR_IRQ_EN:  d.irq_en = q.wdata[2:0];
          default:
          begin
            if (q.awaddr[7:5] == BLK_UNIT_CFG)
            begin
              d.cfg[q.awaddr[4:2]] = q.wdata[7:0];
            end
            else if (q.awaddr[7:5] == BLK_UNIT_TXD)
            begin
              d.txd[q.awaddr[4:2]] = q.wdata[7:0];
            end
          end
        endcase
      end
    end
    if (q.bvalid && s_axi_bready)
    begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end
    if (s_axi_arvalid && q.arready)
    begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rdata   = rd_val;
      d.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rvalid && s_axi_rready)
    begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end

    // set wins over a clear in the same cycle
    d.irq_sts = (q.irq_sts & ~irq_clr) | irq_set;
    d.irq     = |(d.irq_sts & d.irq_en);
    if (wr_hit)
    begin
      d.irq = |(d.irq_sts & d.irq_en);
    end
  end

  // write decode: status and receive words are read only
  always_comb
  begin
    wr_ok = (q.awaddr[1:0] == 2'b00) &&
            (q.awaddr == ADDR_BUS_CTRL || q.awaddr == ADDR_MSG_CTRL ||
             q.awaddr == ADDR_MSG_TXD || q.awaddr == ADDR_IRQ_CLR ||
             q.awaddr == ADDR_IRQ_EN || q.awaddr[7:5] == BLK_UNIT_CFG ||
             q.awaddr[7:5] == BLK_UNIT_TXD);
  end

  // read decode
  always_comb
  begin
    rd_ok  = (s_axi_araddr[1:0] == 2'b00);
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      ADDR_BUS_CTRL:  rd_val = {28'h0, q.sig2_ci, q.dbl, q.mode};
      ADDR_MSG_CTRL:  rd_val = {25'h0, q.msg_event_enable, q.tx_handshake_ctrl, q.msg_on, q.msg_line, q.msg_sel};
      ADDR_MSG_TXD:   rd_val = {24'h0, q.msg_txd};
      ADDR_MSG_STATE: rd_val = {27'h0, q.mst, q.pend, q.mst != TSHM_IDLE};
      ADDR_IRQ_STS:   rd_val = {29'h0, q.irq_sts};
      ADDR_IRQ_EN:    rd_val = {29'h0, q.irq_en};
      ADDR_FRAME:     rd_val = {21'h0, slot, q.octets};
      ADDR_IRQ_CLR:   rd_val = 32'h0000_0000;
      default:
      begin
        if (s_axi_araddr[7:5] == BLK_UNIT_CFG)
        begin
          rd_val = {24'h0, q.cfg[s_axi_araddr[4:2]]};
        end
        else if (s_axi_araddr[7:5] == BLK_UNIT_TXD)
        begin
          rd_val = {24'h0, q.txd[s_axi_araddr[4:2]]};
        end
        else if (s_axi_araddr[7:5] == BLK_UNIT_RXD)
        begin
          rd_val = {24'h0, q.rxd[s_axi_araddr[4:2]]};
        end
        else
        begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q          <= '0;
      q.mst      <= TSHM_IDLE;
      q.mx       <= 1'b1;
      q.mr_cur   <= 1'b1;
      q.mr_last  <= 1'b1;
      q.msg_sel  <= MSG_SEL_RST;
      q.msg_line <= 1'b0;
      q.msg_on   <= 1'b1;
      q.cfg      <= {NUM_UNITS{CFG_RST}};
      q.up_out   <= 1'b1;
      q.dn_out   <= 1'b1;
      q.up_oe_n  <= 1'b1;
      q.dn_oe_n  <= 1'b1;
      q.awready  <= 1'b1;
      q.wready   <= 1'b1;
      q.arready  <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign up_out        = q.up_out;
  assign up_oe_n       = q.up_oe_n;
  assign down_out      = q.dn_out;
  assign down_oe_n     = q.dn_oe_n;
  assign irq           = q.irq;
endmodule
`default_nettype wire

// File: dv/tshm_props.sv
// concurrent checks on the slot handler ports
`timescale 1ns/1ps
`default_nettype none
module tshm_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bit_clk,
  input wire logic down_out,
  input wire logic down_oe_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read not answered");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  line_idle_a: assert property (down_oe_n |-> down_out)
    else $error("released line not high");
  shift_rise_a: assert property ($changed(down_oe_n) |-> bit_clk)
    else $error("line drive changed off rising bit clock");
endmodule
bind tshm_top tshm_chk tshm_chk_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .bit_clk, .down_out,
  .down_oe_n
);
`default_nettype wire

// File: dv/tshm_l1_model.sv
// transceiver model: frame sync, bit clock, upstream pull-down, line capture
`timescale 1ns/1ps
`default_nettype none
module tshm_l1_model (
  input  wire logic       up_w,
  input  wire logic       down_w,
  input  wire logic [4:0] ack_slot,
  input  wire logic       ack_lvl,
  input  wire logic [4:0] dat_slot,
  input  wire logic [7:0] up_byte,
  input  wire logic [6:0] fs_bits,
  output logic            frame_sync,
  output logic            bit_clk,
  output logic            up_drv,
  output int              frames,
  output logic [7:0]      dn_last [12],
  output logic [7:0]      up_last [12]
);
  int s;
  int p;
  initial
  begin
    frame_sync = 1'b0;
    bit_clk = 1'b0;
    up_drv = 1'b1;
    frames = 0;
    forever
    begin
      frame_sync = 1'b1;
      #62.5;
      for (int b = 0; b < 96; b++)
      begin
        s = b / 8;
        p = b % 8;
        bit_clk = 1'b1;
        if (b == fs_bits)
          frame_sync = 1'b0;
        if (s == ack_slot && p == 6)
          up_drv = ack_lvl;
        else if (s == dat_slot)
          up_drv = up_byte[7 - p];
        else
          up_drv = 1'b1;
        #62.5;
        bit_clk = 1'b0;
        dn_last[s][7 - p] = down_w;
        up_last[s][7 - p] = up_w;
        #62.5;
      end
      // clock stands still between frames
      frames++;
      #200;
    end
  end
endmodule
`default_nettype wire

// File: dv/tshm_tb_top.sv
// self-checking bench for the tdm slot handler
`timescale 1ns/1ps
`default_nettype none
module tshm_tb_top;
  import tshm_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        frame_sync;
  logic        bit_clk;
  logic        up_out, up_oe_n, down_out, down_oe_n, irq, up_drv, ack_lvl;
  logic [7:0]  up_byte;
  logic [6:0]  fs_bits;
  logic [7:0]  dn_last [12];
  logic [7:0]  up_last [12];
  logic [31:0] hs;
  int          frames;
  int          errors;
  int          checks_done;
  // open-drain wires: any low driver wins
  wire logic   up_w = (up_oe_n | up_out) & up_drv;
  wire logic   down_w = down_oe_n | down_out;

  always #5 aclk = ~aclk;

  tshm_top tshm_top_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .frame_sync, .bit_clk, .up_in(up_w), .up_out, .up_oe_n, .down_in(down_w),
    .down_out, .down_oe_n, .irq
  );
  tshm_l1_model tshm_l1_model_i (
    .up_w, .down_w, .ack_slot(5'h03), .ack_lvl, .dat_slot(5'h0A), .up_byte,
    .fs_bits, .frame_sync, .bit_clk, .up_drv, .frames, .dn_last, .up_last
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic [7:0] got, input logic [7:0] exp);
    chk({24'h0, got}, {24'h0, exp});
  endtask

  task automatic tmo();
    errors++;
    $display("Error %0t: wait ran out", $time);
    test_done();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 99);
    s_axi_bready <= 1'b0;
    if (n >= 99)
      tmo();
    chk(32'(s_axi_bresp), 32'(RESP_OKAY));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 99);
    s_axi_rready <= 1'b0;
    if (n >= 99)
      tmo();
    chk(s_axi_rdata & m, e);
    chk(32'(s_axi_rresp), 32'(r));
  endtask

  // frames come from the model; bound covers one frame per 3000 cycles
  task automatic wait_fr(input int k);
    int t;
    int f;
    f = frames + k;
    t = 0;
    while (frames < f && t < 3000 * k)
    begin
      @(posedge aclk);
      t++;
    end
    if (frames < f)
      tmo();
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    ack_lvl = 1'b1;
    up_byte = 8'h3C;
    fs_bits = 7'h01;
    errors = 0;
    checks_done = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_MSG_CTRL, 32'hFF, 32'h10, RESP_OKAY);
    rd(ADDR_BUS_CTRL, 32'hFF, 32'h00, RESP_OKAY);
    rd(ADDR_IRQ_STS, 32'h03, 32'h00, RESP_OKAY);
    rd(8'hFC, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    // each unit gets a slot of its own
    wr(8'h50, 32'h4A);
    wr(8'h70, 32'hA5);
    wr(8'h54, 32'hC9);
    wr(8'h74, 32'h96);
    wr(8'h48, 32'h48);
    wr(8'h68, 32'h00);
    wait_fr(2);
    chkb(dn_last[10], 8'hA5);
    chkb(up_last[9], 8'h96);
    chkb(dn_last[8], 8'hFC);
    rd(8'h90, 32'hFF, 32'h3C, RESP_OKAY);
    // long sync pulse must not move the slots
    fs_bits <= 7'd40;
    wait_fr(2);
    chkb(dn_last[10], 8'hA5);
    fs_bits <= 7'h01;
    wr(ADDR_IRQ_EN, 32'h3);
    wr(ADDR_MSG_TXD, 32'h5A);
    wr(ADDR_MSG_CTRL, 32'h70);
    wait_fr(3);
    chkb(dn_last[2], 8'h5A);
    chkb(dn_last[3] & 8'h01, 8'h00);
    rd(ADDR_MSG_STATE, 32'h1, 32'h1, RESP_OKAY);
    chk(32'(irq), 32'h0);
    ack_lvl <= 1'b0;
    wait_fr(2);
    rd(ADDR_IRQ_STS, 32'h3, 32'h1, RESP_OKAY);
    chk(32'(irq), 32'h1);
    wr(ADDR_IRQ_EN, 32'h0);
    rd(ADDR_IRQ_STS, 32'h3, 32'h1, RESP_OKAY);
    chk(32'(irq), 32'h0);
    wr(ADDR_IRQ_EN, 32'h3);
    wr(ADDR_IRQ_CLR, 32'h3);
    rd(ADDR_IRQ_STS, 32'h3, 32'h0, RESP_OKAY);
    chk(32'(irq), 32'h0);
    hs = 32'h0;
    wr(ADDR_MSG_TXD, 32'h33);
    repeat (3)
    begin
      wait_fr(1);
      hs = hs + {31'h0, dn_last[3][0]};
    end
    chk(hs, 32'h1);
    chkb(dn_last[2], 8'h33);
    ack_lvl <= 1'b1;
    wait_fr(1);
    ack_lvl <= 1'b0;
    wait_fr(2);
    rd(ADDR_IRQ_STS, 32'h3, 32'h1, RESP_OKAY);
    wr(ADDR_IRQ_CLR, 32'h3);
    ack_lvl <= 1'b1;
    wait_fr(3);
    rd(ADDR_IRQ_STS, 32'h3, 32'h2, RESP_OKAY);
    chk(32'(irq), 32'h1);
    wr(ADDR_IRQ_CLR, 32'h3);
    wr(ADDR_MSG_CTRL, 32'h50);
    wait_fr(3);
    chkb(dn_last[3] & 8'h01, 8'h01);
    rd(ADDR_MSG_STATE, 32'h1, 32'h0, RESP_OKAY);
    wr(ADDR_MSG_TXD, 32'hC3);
    wr(ADDR_MSG_CTRL, 32'h79);
    wait_fr(2);
    chkb(up_last[6], 8'hC3);
    chkb(up_last[7] & 8'h01, 8'h00);
    chkb(dn_last[6], 8'hFF);
    // second signal channel moved into bits 7:6 of slot 7
    wr(ADDR_BUS_CTRL, 32'h08);
    wr(8'h4C, 32'h40);
    wr(8'h6C, 32'h40);
    wait_fr(2);
    chkb(dn_last[7], 8'h7F);
    test_done();
  end
endmodule
`default_nettype wire
